//--- lbad_window.sv
// local bus address decoder: shared constants, types and window compare
package lbad_pkg;
  // ****************************************************
  // bus codes
  // ****************************************************
  localparam logic [1:0] XT_IACK   = 2'h3;
  localparam logic [1:0] SZ_LONG   = 2'h0;
  localparam logic [1:0] SZ_BYTE   = 2'h1;
  localparam logic [1:0] SZ_WORD   = 2'h2;
  // ****************************************************
  // main map
  // ****************************************************
  localparam logic [31:0] EXT_TOP      = 32'hff7fffff;
  localparam logic [9:0]  FLASH_TAG    = 10'h3fe;      // ff800000, 4mb
  localparam logic [10:0] RSVD_TAG     = 11'h7fe;      // ffc00000, 2mb
  localparam logic [11:0] SRAM_TAG     = 12'hffe;      // ffe00000, 1mb
  localparam logic [11:0] LIO_TAG      = 12'hfff;      // fff00000
  localparam logic [15:0] A16_TAG      = 16'hffff;     // ffff0000, 64kb
  localparam logic [31:0] BOOT_ROM_EXTENT = 32'h00020000;
  localparam logic [31:0] REMAP_REG    = 32'hfff42000;
  localparam logic [31:0] REMAP_WORD   = 32'hfff42002;
  localparam int          REMAP_BIT    = 15;
  // ****************************************************
  // local io windows, first and last byte
  // ****************************************************
  localparam logic [31:0] LREGS_LO = 32'hfff40000;
  localparam logic [31:0] LREGS_HI = 32'hfff400ff;
  localparam logic [31:0] GREGS_LO = 32'hfff40100;
  localparam logic [31:0] GREGS_HI = 32'hfff401ff;
  localparam logic [31:0] VSBR_LO  = 32'hfff41000;
  localparam logic [31:0] VSBR_HI  = 32'hfff41fff;
  localparam logic [31:0] PCC_LO   = 32'hfff42000;
  localparam logic [31:0] PCC_HI   = 32'hfff42fff;
  localparam logic [31:0] ECC_LO   = 32'hfff43000;
  localparam logic [31:0] ECC_HI   = 32'hfff43fff;
  localparam logic [31:0] SER_LO   = 32'hfff45000;
  localparam logic [31:0] SER_HI   = 32'hfff451ff;
  localparam logic [31:0] PIT_LO   = 32'hfff45e00;
  localparam logic [31:0] PIT_HI   = 32'hfff45fff;
  localparam logic [31:0] LAN_LO   = 32'hfff46000;
  localparam logic [31:0] LAN_HI   = 32'hfff46fff;
  localparam logic [31:0] SCSI_LO  = 32'hfff47000;
  localparam logic [31:0] SCSI_HI  = 32'hfff47fff;
  localparam logic [31:0] RACK1_LO = 32'hfff70000;
  localparam logic [31:0] RACK1_HI = 32'hfff76fff;
  localparam logic [31:0] RACK2_LO = 32'hfff78000;
  localparam logic [31:0] RACK2_HI = 32'hfff7efff;
  localparam logic [31:0] ROM_LO   = 32'hfff80000;
  localparam logic [31:0] ROM_HI   = 32'hfff9ffff;
  localparam logic [31:0] BBR_LO   = 32'hfffc0000;
  localparam logic [31:0] BBR_HI   = 32'hfffcffff;
  // ****************************************************
  // vme short io space modifiers
  // ****************************************************
  localparam logic [5:0] AM_A16_USER = 6'h29;
  localparam logic [5:0] AM_A16_SUP  = 6'h2d;
  // ****************************************************
  // local bus timeout
  // ****************************************************
  localparam int TMO_8_US   = 8;
  localparam int TMO_64_US  = 64;
  localparam int TMO_256_US = 256;
  localparam int CLK_MHZ    = 125;
  localparam int TMO_8_CYC  = TMO_8_US * CLK_MHZ;
  localparam int TMO_W      = 16;
  typedef enum logic [1:0] {
    TSEL_8US  = 2'b00,
    TSEL_64US = 2'b01,
    TSEL_256US = 2'b10,
    TSEL_INF  = 2'b11
  } lbad_tsel_t;
  typedef enum logic [1:0] {
    PS_D32 = 2'b00,
    PS_D16 = 2'b01,
    PS_D8  = 2'b10,
    PS_DYN = 2'b11
  } lbad_ps_t;
  // ****************************************************
  // carriers
  // ****************************************************
  typedef struct packed {
    logic [31:0] addr;
    logic [1:0]  xtype;
    logic [1:0]  size;
    logic        write;
    logic [31:0] wdata;
  } lbad_req_t;
  typedef struct packed {
    logic        dram_en;
    logic [31:0] dram_top;
    logic        vme_en;
    logic [31:0] vme_lo;
    logic [31:0] vme_hi;
    logic        vsb_en;
    logic [31:0] vsb_lo;
    logic [31:0] vsb_hi;
    logic        vslv_en;
    logic [31:0] vslv_lo;
    logic [31:0] vslv_hi;
    logic [63:0] vslv_am_ok;
    logic        gregs_en;
    logic [7:0]  gregs_base;
    logic        bslv_en;
    logic [31:0] bslv_lo;
    logic [31:0] bslv_hi;
  } lbad_cfg_t;
  typedef struct packed {
    logic dram, vme, vsb, flash, sram, eprom, lregs, gregs, vsbr;
    logic pcc, ecc, ser, pit, lan, scsi, bbram, iack;
  } lbad_sel_t;
endpackage

`timescale 1ns/1ps
// ****************************************************
// inclusive address window compare
// ****************************************************
module lbad_window (
  input  wire logic [31:0] addr_i,
  input  wire logic [31:0] lo_i,
  input  wire logic [31:0] hi_i,
  input  wire logic        en_i,
  output logic             hit_o
);
  // hit when enabled and lo <= addr <= hi
  assign hit_o = en_i && (addr_i >= lo_i) && (addr_i <= hi_i);
endmodule

//--- lbad_decoder.sv
// local bus address decoder with cycle termination and inbound decoders
`timescale 1ns/1ps
module lbad_decoder #(
  parameter int unsigned TMO_64_CYC  = lbad_pkg::TMO_64_US * lbad_pkg::CLK_MHZ,
  parameter int unsigned TMO_256_CYC = lbad_pkg::TMO_256_US * lbad_pkg::CLK_MHZ
) (
  input  wire logic                clk_sys_i,
  input  wire logic                rst_i,
  input  wire logic                start_i,
  input  wire lbad_pkg::lbad_req_t req_i,
  input  wire logic                target_ack_i,
  input  wire logic                irq_pending_i,
  input  wire logic                timer_en_i,
  input  wire lbad_pkg::lbad_tsel_t tmo_sel_i,
  input  wire logic                cfg_load_i,
  input  wire lbad_pkg::lbad_cfg_t cfg_i,
  input  wire logic                vme_strobe_i,
  input  wire logic [31:0]         vme_addr_i,
  input  wire logic [5:0]          vme_am_i,
  input  wire logic                vsb_strobe_i,
  input  wire logic [31:0]         vsb_addr_i,
  output lbad_pkg::lbad_sel_t      sel_o,
  output lbad_pkg::lbad_ps_t       port_size_o,
  output logic                     ack_o,
  output logic                     transfer_error_ack_o,
  output logic                     boot_remap_bit_o,
  output logic                     vme_slave_sel_o,
  output logic                     vme_gregs_sel_o,
  output logic                     vsb_slave_sel_o
);
  // ****************************************************
  // types and state
  // ****************************************************
  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_WAIT  = 2'b01,
    ST_NOACK = 2'b10
  } lbad_st_t;
  typedef enum logic [1:0] {
    K_NONE = 2'b00,
    K_TGT  = 2'b01,
    K_SELF = 2'b10,
    K_ERR  = 2'b11
  } lbad_kind_t;

  lbad_st_t                 st_reg, st_next;
  lbad_pkg::lbad_sel_t      sel_reg, sel_next, dec_sel;
  lbad_pkg::lbad_ps_t       ps_reg, ps_next, dec_ps;
  lbad_kind_t               dec_kind;
  logic                     ack_reg, ack_next;
  logic                     terr_reg, terr_next;
  logic                     remap_reg, remap_next;
  logic [lbad_pkg::TMO_W-1:0] cnt_reg, cnt_next;
  logic [lbad_pkg::TMO_W-1:0] tmo_lim;
  logic                     tmo_inf;
  lbad_pkg::lbad_cfg_t      cfg_reg, cfg_next;
  logic                     vslv_reg, vslv_next;
  logic                     gregs_reg, gregs_next;
  logic                     bslv_reg, bslv_next;
  logic                     hit_dram, hit_vme, hit_vsb, hit_vslv, hit_bslv;
  logic                     normal_xt, narrow_wr, remap_wr, ext_cycle;
  logic [31:0]              a;

  assign a = req_i.addr;

  // ****************************************************
  // programmable windows
  // ****************************************************
  // dram decoder from zero to just below its top bound
  lbad_window u_dram (
    .addr_i (a),
    .lo_i   (32'h00000000),
    .hi_i   (cfg_reg.dram_top - 32'h00000001),
    .en_i   (cfg_reg.dram_en && (cfg_reg.dram_top != 32'h00000000)),
    .hit_o  (hit_dram)
  );
  // local to vme and vsb master windows
  lbad_window u_vme (
    .addr_i (a),
    .lo_i   (cfg_reg.vme_lo),
    .hi_i   (cfg_reg.vme_hi),
    .en_i   (cfg_reg.vme_en),
    .hit_o  (hit_vme)
  );
  lbad_window u_vsb (
    .addr_i (a),
    .lo_i   (cfg_reg.vsb_lo),
    .hi_i   (cfg_reg.vsb_hi),
    .en_i   (cfg_reg.vsb_en),
    .hit_o  (hit_vsb)
  );
  // inbound vme slave and vsb slave windows
  lbad_window u_vslv (
    .addr_i (vme_addr_i),
    .lo_i   (cfg_reg.vslv_lo),
    .hi_i   (cfg_reg.vslv_hi),
    .en_i   (cfg_reg.vslv_en),
    .hit_o  (hit_vslv)
  );
  lbad_window u_bslv (
    .addr_i (vsb_addr_i),
    .lo_i   (cfg_reg.bslv_lo),
    .hi_i   (cfg_reg.bslv_hi),
    .en_i   (cfg_reg.bslv_en),
    .hit_o  (hit_bslv)
  );

  // ****************************************************
  // access decode
  // ****************************************************
  assign normal_xt = (req_i.xtype != lbad_pkg::XT_IACK);
  assign narrow_wr = req_i.write && (req_i.size != lbad_pkg::SZ_LONG);

  // pick one target, a self answer, an error or nothing
  always_comb begin
    dec_sel  = '0;
    dec_ps   = lbad_pkg::PS_D32;
    dec_kind = K_TGT;
    if (!normal_xt) begin
      dec_ps = lbad_pkg::PS_D8;
      if (irq_pending_i) begin
        dec_sel.iack = 1'b1;
      end else begin
        dec_kind = K_NONE;
      end
    end else if (remap_reg && a < lbad_pkg::BOOT_ROM_EXTENT) begin
      dec_sel.eprom = 1'b1;
    end else if (hit_dram) begin
      dec_sel.dram = 1'b1;
    end else if (a <= lbad_pkg::EXT_TOP) begin
      dec_ps = lbad_pkg::PS_DYN;
      if (hit_vme) begin
        dec_sel.vme = 1'b1;
      end else if (hit_vsb) begin
        dec_sel.vsb = 1'b1;
      end else begin
        dec_kind = K_NONE;
      end
    end else if (a[31:22] == lbad_pkg::FLASH_TAG) begin
      dec_sel.flash = 1'b1;
    end else if (a[31:21] == lbad_pkg::RSVD_TAG) begin
      dec_kind = K_NONE;
    end else if (a[31:20] == lbad_pkg::SRAM_TAG) begin
      dec_sel.sram = 1'b1;
    end else if (a[31:16] == lbad_pkg::A16_TAG) begin
      dec_ps = lbad_pkg::PS_DYN;
      if (cfg_reg.vme_en) begin
        dec_sel.vme = 1'b1;
      end else begin
        dec_kind = K_NONE;
      end
    end else begin
      // local io region, ports from 8 to 32 bits
      if (a >= lbad_pkg::LREGS_LO && a <= lbad_pkg::LREGS_HI) begin
        if (narrow_wr) begin
          dec_kind = K_ERR;
        end else begin
          dec_sel.lregs = 1'b1;
        end
      end else if (a >= lbad_pkg::GREGS_LO && a <= lbad_pkg::GREGS_HI) begin
        dec_sel.gregs = 1'b1;
        dec_ps       = lbad_pkg::PS_DYN;
      end else if (a >= lbad_pkg::VSBR_LO && a <= lbad_pkg::VSBR_HI) begin
        dec_sel.vsbr = 1'b1;
      end else if (a >= lbad_pkg::PCC_LO && a <= lbad_pkg::PCC_HI) begin
        dec_sel.pcc = 1'b1;
      end else if (a >= lbad_pkg::ECC_LO && a <= lbad_pkg::ECC_HI) begin
        dec_sel.ecc = 1'b1;
        dec_ps      = lbad_pkg::PS_D8;
      end else if (a >= lbad_pkg::SER_LO && a <= lbad_pkg::SER_HI) begin
        dec_sel.ser = 1'b1;
        dec_ps      = lbad_pkg::PS_D16;
      end else if (a >= lbad_pkg::PIT_LO && a <= lbad_pkg::PIT_HI) begin
        dec_sel.pit = 1'b1;
        dec_ps      = lbad_pkg::PS_D8;
      end else if (a >= lbad_pkg::LAN_LO && a <= lbad_pkg::LAN_HI) begin
        dec_sel.lan = 1'b1;
      end else if (a >= lbad_pkg::SCSI_LO && a <= lbad_pkg::SCSI_HI) begin
        dec_sel.scsi = 1'b1;
      end else if ((a >= lbad_pkg::RACK1_LO && a <= lbad_pkg::RACK1_HI) ||
                   (a >= lbad_pkg::RACK2_LO && a <= lbad_pkg::RACK2_HI)) begin
        dec_kind = K_SELF;
      end else if (a >= lbad_pkg::ROM_LO && a <= lbad_pkg::ROM_HI) begin
        dec_sel.eprom = 1'b1;
      end else if (a >= lbad_pkg::BBR_LO && a <= lbad_pkg::BBR_HI) begin
        dec_sel.bbram = 1'b1;
        dec_ps        = lbad_pkg::PS_DYN;
      end else begin
        dec_kind = K_NONE;
      end
    end
  end

  // ****************************************************
  // boot remap snoop and timeout limit
  // ****************************************************
  // a write carrying bit 15 of the remap register updates the copy
  // only a cycle that is really taken may change the copy
  assign remap_wr = start_i && st_reg == ST_IDLE && req_i.write && normal_xt &&
                    ((a == lbad_pkg::REMAP_REG && req_i.size == lbad_pkg::SZ_LONG) ||
                     (a == lbad_pkg::REMAP_WORD && req_i.size != lbad_pkg::SZ_LONG));
  assign ext_cycle = sel_reg.vme || sel_reg.vsb;

  // timeout length from the selected range
  always_comb begin
    tmo_inf = 1'b0;
    case (tmo_sel_i)
      lbad_pkg::TSEL_8US:   tmo_lim = lbad_pkg::TMO_W'(lbad_pkg::TMO_8_CYC);
      lbad_pkg::TSEL_64US:  tmo_lim = lbad_pkg::TMO_W'(TMO_64_CYC);
      lbad_pkg::TSEL_256US: tmo_lim = lbad_pkg::TMO_W'(TMO_256_CYC);
      default: begin
        tmo_lim = '1;
        tmo_inf = 1'b1;
      end
    endcase
  end

  // ****************************************************
  // cycle state machine
  // ****************************************************
  always_comb begin
    st_next    = st_reg;
    sel_next   = sel_reg;
    ps_next    = ps_reg;
    ack_next   = 1'b0;
    terr_next  = 1'b0;
    cnt_next   = cnt_reg;
    remap_next = remap_reg;
    if (remap_wr) begin
      remap_next = req_i.wdata[lbad_pkg::REMAP_BIT];
    end
    case (st_reg)
      ST_IDLE: begin
        cnt_next = '0;
        if (start_i) begin
          case (dec_kind)
            K_TGT: begin
              sel_next = dec_sel;
              ps_next  = dec_ps;
              st_next  = ST_WAIT;
            end
            K_SELF:  ack_next = 1'b1;
            K_ERR:   terr_next = 1'b1;
            default: st_next  = ST_NOACK;
          endcase
        end
      end
      ST_WAIT: begin
        if (target_ack_i) begin
          ack_next = 1'b1;
          sel_next = '0;
          st_next  = ST_IDLE;
        end else if (!ext_cycle && timer_en_i && !tmo_inf) begin
          cnt_next = cnt_reg + 1'b1;
          if (cnt_reg >= tmo_lim - 1'b1) begin
            terr_next = 1'b1;
            sel_next = '0;
            st_next  = ST_IDLE;
          end
        end
      end
      ST_NOACK: begin
        // never acknowledged; only the timer ends it
        if (timer_en_i && !tmo_inf) begin
          cnt_next = cnt_reg + 1'b1;
          if (cnt_reg >= tmo_lim - 1'b1) begin
            terr_next = 1'b1;
            st_next  = ST_IDLE;
          end
        end
      end
      default: begin
        st_next  = ST_IDLE;
        sel_next = '0;
      end
    endcase
  end

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      st_reg    <= ST_IDLE;
      sel_reg   <= '0;
      ps_reg    <= lbad_pkg::PS_D32;
      ack_reg   <= 1'b0;
      terr_reg  <= 1'b0;
      cnt_reg   <= '0;
      remap_reg <= 1'b1;
    end else begin
      st_reg    <= st_next;
      sel_reg   <= sel_next;
      ps_reg    <= ps_next;
      ack_reg   <= ack_next;
      terr_reg  <= terr_next;
      cnt_reg   <= cnt_next;
      remap_reg <= remap_next;
    end
  end

  // ****************************************************
  // configuration and inbound decoders
  // ****************************************************
  always_comb begin
    cfg_next  = cfg_load_i ? cfg_i : cfg_reg;
    vslv_next = vme_strobe_i && hit_vslv && cfg_reg.vslv_am_ok[vme_am_i];
    gregs_next = vme_strobe_i && cfg_reg.gregs_en &&
                (vme_am_i == lbad_pkg::AM_A16_USER || vme_am_i == lbad_pkg::AM_A16_SUP) &&
                (vme_addr_i[15:8] == cfg_reg.gregs_base);
    bslv_next = vsb_strobe_i && hit_bslv;
  end

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      cfg_reg  <= '0;
      vslv_reg <= 1'b0;
      gregs_reg <= 1'b0;
      bslv_reg <= 1'b0;
    end else begin
      cfg_reg  <= cfg_next;
      vslv_reg <= vslv_next;
      gregs_reg <= gregs_next;
      bslv_reg <= bslv_next;
    end
  end

  // ****************************************************
  // outputs
  // ****************************************************
  assign sel_o                = sel_reg;
  assign port_size_o          = ps_reg;
  assign ack_o                = ack_reg;
  assign transfer_error_ack_o = terr_reg;
  assign boot_remap_bit_o     = remap_reg;
  assign vme_slave_sel_o      = vslv_reg;
  assign vme_gregs_sel_o      = gregs_reg;
  assign vsb_slave_sel_o      = bslv_reg;

  // ****************************************************
  // assertions
  // ****************************************************
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);

  a_lregs_narrow_err: assert property (
    start_i && st_reg == ST_IDLE && normal_xt && narrow_wr && a >= lbad_pkg::LREGS_LO &&
    a <= lbad_pkg::LREGS_HI && !(remap_reg && a < lbad_pkg::BOOT_ROM_EXTENT)
    |=> transfer_error_ack_o && sel_o == '0)
    else $error("narrow local regs write not ended by error");
  a_gregs_any_width: assert property (
    start_i && st_reg == ST_IDLE && normal_xt && a >= lbad_pkg::GREGS_LO &&
    a <= lbad_pkg::GREGS_HI |=> sel_o.gregs && !transfer_error_ack_o)
    else $error("global regs window access refused");
  a_rsvd_self_ack: assert property (
    start_i && st_reg == ST_IDLE && normal_xt && a >= lbad_pkg::RACK1_LO &&
    a <= lbad_pkg::RACK1_HI |=> ack_o && st_reg == ST_IDLE)
    else $error("reserved block not acknowledged");
  a_undecoded_quiet: assert property (
    start_i && st_reg == ST_IDLE && normal_xt && a[31:21] == lbad_pkg::RSVD_TAG
    |=> (st_reg == ST_NOACK && !ack_o)[*2])
    else $error("undecoded area answered");
  a_noack_timeout: assert property (
    st_reg == ST_NOACK && timer_en_i && tmo_sel_i == lbad_pkg::TSEL_8US &&
    cnt_reg == lbad_pkg::TMO_W'(lbad_pkg::TMO_8_CYC - 1)
    |=> transfer_error_ack_o && st_reg == ST_IDLE)
    else $error("timeout did not end the cycle");
  a_sel_onehot: assert property ($onehot0(sel_o))
    else $error("more than one target selected");
  a_boot_at_zero: assert property (
    start_i && st_reg == ST_IDLE && normal_xt && remap_reg && a == 32'h00000000
    |=> sel_o.eprom && !sel_o.dram)
    else $error("boot rom missing at zero");
  a_iack_gate: assert property (
    start_i && st_reg == ST_IDLE && !normal_xt && !irq_pending_i
    |=> !sel_o.iack && st_reg == ST_NOACK)
    else $error("vector answered with no interrupt pending");
  a_ext_untimed: assert property (
    st_reg == ST_WAIT && ext_cycle |-> !transfer_error_ack_o ##1 !transfer_error_ack_o)
    else $error("external bus cycle timed out locally");
  a_dram_off: assert property (!cfg_reg.dram_en |-> ##1 !sel_o.dram)
    else $error("disabled dram decoder selected");

  c_target_ack: cover property (st_reg == ST_WAIT ##1 ack_o);
  c_timeout: cover property (st_reg == ST_NOACK ##1 transfer_error_ack_o);
  c_remap_off: cover property ($fell(remap_reg));
  c_vme_slave: cover property (vme_slave_sel_o);
endmodule

//--- lbad_target.sv
// partner model: local bus target answering each select after a set delay
`timescale 1ns/1ps
module lbad_target (
  input  wire logic                clk_sys_i,
  input  wire logic                rst_i,
  input  wire lbad_pkg::lbad_sel_t sel_i,
  input  wire logic [3:0]          delay_i,
  output logic                     ack_o
);
  logic [3:0] cnt_reg;
  logic       done_reg;
  // one acknowledge pulse per select, delay_i + 1 cycles after it opens
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      cnt_reg  <= 4'h0;
      done_reg <= 1'b0;
      ack_o    <= 1'b0;
    end else begin
      ack_o <= 1'b0;
      if (sel_i == '0) begin
        cnt_reg  <= 4'h0;
        done_reg <= 1'b0;
      end else if (!done_reg && cnt_reg == delay_i) begin
        ack_o    <= 1'b1;
        done_reg <= 1'b1;
      end else begin
        cnt_reg <= cnt_reg + 4'h1;
      end
    end
  end
endmodule

//--- local_bus_address_decoder_bench.sv
// testbench for the local bus address decoder
`timescale 1ns/1ps
module local_bus_address_decoder_bench;
  logic clk_sys_i = 0, rst_i = 1, start_i = 0, tack, irq = 0, cld = 0, vstb = 0;
  lbad_pkg::lbad_req_t req = '0;
  lbad_pkg::lbad_cfg_t cfg = '0;
  lbad_pkg::lbad_sel_t sel;
  logic [31:0] vaddr = 0, rnd;
  logic [5:0]  vam = 0;
  logic [3:0]  dly = 0;
  logic ack, terr, remap, vsel, gsel, bsel, ten = 1;
  lbad_pkg::lbad_tsel_t tsel = lbad_pkg::TSEL_64US;
  lbad_pkg::lbad_ps_t   ps;
  logic [18:0] q[$];
  logic [16:0] seen = 0;
  int bad_count = 0, n_checks = 0, cyc = 0;
  always #4 clk_sys_i = ~clk_sys_i;
  lbad_decoder #(.TMO_64_CYC(20), .TMO_256_CYC(40)) dut (.clk_sys_i(clk_sys_i),
    .rst_i(rst_i), .start_i(start_i), .req_i(req), .target_ack_i(tack),
    .irq_pending_i(irq), .timer_en_i(ten), .tmo_sel_i(tsel),
    .cfg_load_i(cld), .cfg_i(cfg), .vme_strobe_i(vstb), .vme_addr_i(vaddr),
    .vme_am_i(vam), .vsb_strobe_i(vstb), .vsb_addr_i(vaddr), .sel_o(sel),
    .port_size_o(ps), .ack_o(ack), .transfer_error_ack_o(terr),
    .boot_remap_bit_o(remap), .vme_slave_sel_o(vsel), .vme_gregs_sel_o(gsel),
    .vsb_slave_sel_o(bsel));
  lbad_target tgt (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .sel_i(sel),
    .delay_i(dly), .ack_o(tack));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t: %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // one local bus cycle; res 1 = acknowledge, 2 = transfer error
  task automatic acc(input logic [31:0] a, input logic [1:0] t, input logic [1:0] sz,
                     input logic w, input logic [1:0] res, input logic [16:0] s);
    q.push_back({res, s});
    dly <= 4'($urandom % 4);
    req <= '{addr: a, xtype: t, size: sz, write: w, wdata: 32'h0};
    start_i <= 1'b1;
    @(posedge clk_sys_i);
    start_i <= 1'b0;
    repeat (64) begin
      @(posedge clk_sys_i);
      if (ack || terr) break;
    end
    $display("test at %h ended", a);
  endtask
  // monitor: pair each answer with the oldest noted expectation
  always @(negedge clk_sys_i) begin
    seen = seen | sel;
    if (ack || terr) begin
      if (q.size() == 0) chk(1, 0, "extra answer");
      else begin
        chk({terr, ack}, q[0][18:17], "answer");
        chk(seen, q.pop_front() & 17'h1ffff, "select");
      end
      seen = 0;
    end
  end
  always @(posedge clk_sys_i) if (++cyc == 5000) begin
    bad_count++;
    results();
  end
  initial begin
    rnd = $urandom(32'hc2f18f43);
    repeat (2) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    @(negedge clk_sys_i);
    chk(remap, 1, "remap after reset");
    @(posedge clk_sys_i);
    for (int t = 0; t < 3; t++) acc($urandom & 32'h1fffc, t, 0, 0, 1, 17'h00800);
    acc(32'hffc00000 + ($urandom & 32'h1fffff), 0, 0, 0, 2, 0);
    acc(32'hfff45200 + ($urandom % 32'hc00), 0, 1, 0, 2, 0);
    // timer off: the cycle must hang until the timer is switched on
    ten <= 1'b0;
    tsel <= lbad_pkg::TSEL_256US;
    acc(32'hfff00000 + ($urandom & 32'h3fffc), 0, 0, 0, 2, 0);
    chk(q.size(), 1, "answer with timer off");
    ten <= 1'b1;
    repeat (50) @(posedge clk_sys_i);
    chk(q.size(), 0, "timer did not end hung cycle");
    tsel <= lbad_pkg::TSEL_64US;
    acc(32'hfff70000, 0, 0, 0, 1, 0);
    acc(32'hfff78000, 0, 0, 0, 1, 0);
    acc(32'hff800000 + ($urandom & 32'h3ffffc), 1, 0, 0, 1, 17'h02000);
    acc(32'hffe00000 + ($urandom & 32'hffffc), 2, 0, 1, 1, 17'h01000);
    acc(32'hfff40010, 0, 1, 1, 2, 0);
    acc(32'hfff40010, 0, 2, 1, 2, 0);
    acc(32'hfff40010, 0, 0, 1, 1, 17'h00400);
    acc(32'hfff40103, 0, 1, 1, 1, 17'h00200);
    chk(ps, lbad_pkg::PS_DYN, "port size");
    acc(32'hfff40012, 0, 2, 0, 1, 17'h00400);
    acc(32'hfff46000, 0, 2, 1, 1, 17'h00008);
    acc(32'hfff46002, 0, 2, 1, 1, 17'h00008);
    acc($urandom & 32'hfffffff0, 3, 1, 0, 2, 0);
    irq <= 1'b1;
    acc($urandom & 32'hfffffff0, 3, 1, 0, 1, 17'h00001);
    acc(32'hfff42000, 0, 0, 1, 1, 17'h00080);
    chk(remap, 0, "remap cleared");
    acc(32'h00000400, 0, 0, 0, 2, 0);
    cfg.dram_en <= 1'b1;
    cfg.dram_top <= 32'h00100000;
    cfg.vslv_en <= 1'b1;
    cfg.vslv_hi <= 32'h0000ffff;
    cfg.vslv_am_ok <= '1;
    cfg.bslv_en <= 1'b1;
    cfg.bslv_hi <= 32'h0000ffff;
    cfg.gregs_en <= 1'b1;
    cld <= 1'b1;
    @(posedge clk_sys_i);
    cld <= 1'b0;
    acc(32'h00000400, 0, 0, 0, 1, 17'h10000);
    acc(32'h00100000 - 4, 0, 0, 0, 1, 17'h10000);
    vstb <= 1'b1;
    vaddr <= $urandom & 32'h00fc;
    vam <= ($urandom % 2) ? lbad_pkg::AM_A16_USER : lbad_pkg::AM_A16_SUP;
    @(posedge clk_sys_i);
    vstb <= 1'b0;
    @(negedge clk_sys_i);
    chk(vsel, 1, "vme slave select");
    chk(gsel, 1, "global regs select");
    chk(bsel, 1, "vsb slave select");
    $display("test inbound ended");
    chk(q.size(), 0, "pending answers");
    results();
  end
endmodule
